// File: design/drp_diag_read_port.sv
// Diagnostic read port: command interpreter over a byte stream
`default_nettype none
module drp_diag_read_port
  import drp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic frameStart,
  input wire logic frameEnd,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic txReq,
  input wire logic statusSetEn,
  input wire logic [5:0] statusSetIdx,
  input wire logic [7:0] statusSetData,
  output logic [7:0] txData,
  output logic txValid,
  output logic cmdError,
  output logic pendingValid
);

  // ==========================================================
  // Reset release
  logic [1:0] rstPipe_reg;
  logic rstSync;

  // Async assert, two-flop synchronous release
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rstPipe_reg <= 2'b00;
    else
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
  end
  assign rstSync = rstPipe_reg[1];

  // ==========================================================
  // Command decoding
  drp_state_t state_reg;
  drp_state_t state_next;
  logic [3:0] paramCnt_reg;
  logic [7:0] reqOp_reg;
  logic [31:0] parBuf_reg;
  logic [63:0] clrMask_reg;
  logic [15:0] parStart;
  logic [15:0] parCount;
  logic [16:0] parSpan;
  logic reqLegal;
  logic pfDone;
  logic clrDone;

  assign parStart = parBuf_reg[START_LSB +: 16];
  assign parCount = parBuf_reg[COUNT_LSB +: 16];
  assign parSpan = {1'b0, parStart} + {1'b0, parCount};
  // Only the status read is known; wrong count or range is refused
  assign reqLegal = (reqOp_reg == OP_STATUS_RD)
    && (paramCnt_reg == STATUS_RD_PARAMS)
    && (parStart <= START_MAX)
    && (parCount >= COUNT_MIN) && (parSpan <= SPAN_MAX);
  assign pfDone = frameEnd
    && (state_reg == DRP_PFPAR || state_reg == DRP_PFOP);
  assign clrDone = frameEnd && (state_reg == DRP_CLR)
    && (paramCnt_reg == CLR_MASK_BYTES);

  // Next state from frame markers and the first two bytes of each frame
  always_comb
  begin
    state_next = state_reg;
    if (frameStart)
      state_next = DRP_OPC;
    else if (frameEnd)
      state_next = DRP_IDLE;
    else if (rxValid)
    begin
      case (state_reg)
        DRP_OPC:
        begin
          case (rxData)
            OP_PREFETCH: state_next = DRP_PFOP;
            OP_ACTIVATE: state_next = DRP_ACT;
            OP_STATUS_CLR: state_next = DRP_CLR;
            default: state_next = DRP_DROP;
          endcase
        end
        DRP_PFOP: state_next = DRP_PFPAR;
        DRP_ACT: state_next = DRP_DROP;
        default: state_next = state_reg;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
      state_reg <= DRP_IDLE;
    else
      state_reg <= state_next;
  end

  // Parameter collection; counter saturates so overruns stay visible
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      paramCnt_reg <= 4'h0;
      reqOp_reg <= 8'h00;
      parBuf_reg <= 32'h0000_0000;
      clrMask_reg <= 64'h0;
    end
    else if (frameStart)
      paramCnt_reg <= 4'h0;
    else if (rxValid)
    begin
      if (state_reg == DRP_PFOP)
        reqOp_reg <= rxData;
      if (state_reg == DRP_PFPAR || state_reg == DRP_CLR)
      begin
        if (paramCnt_reg != PARAM_CNT_MAX)
          paramCnt_reg <= paramCnt_reg + 4'h1;
        // Little-endian: byte k lands at bits 8k+7..8k
        if (state_reg == DRP_PFPAR && paramCnt_reg < STATUS_RD_PARAMS)
          parBuf_reg[{paramCnt_reg[1:0], 3'b000} +: 8] <= rxData;
        if (state_reg == DRP_CLR && paramCnt_reg < CLR_MASK_BYTES)
          clrMask_reg[8 * paramCnt_reg[2:0] +: 8] <= rxData;
      end
    end
  end

  // ==========================================================
  // Pending read and retrieval
  logic [5:0] pendStart_reg;
  logic [6:0] pendCount_reg;
  logic pendValid_reg;
  logic [5:0] rdPtr_reg;
  logic [6:0] remain_reg;
  logic actHit;
  logic [7:0] store [STORE_BYTES];
  logic [7:0] curByte;
  logic serveHit;

  assign actHit = rxValid && state_reg == DRP_OPC && rxData == OP_ACTIVATE;
  assign curByte = store[rdPtr_reg];
  assign serveHit = txReq && state_reg == DRP_ACT && remain_reg != 7'h00;
  assign pendingValid = pendValid_reg;

  // Newest request overwrites any unretrieved one without error
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      pendValid_reg <= 1'b0;
      pendStart_reg <= 6'h00;
      pendCount_reg <= 7'h00;
    end
    else if (pfDone)
    begin
      pendValid_reg <= reqLegal;
      pendStart_reg <= parStart[5:0];
      pendCount_reg <= parCount[6:0];
    end
    else if (frameEnd && state_reg == DRP_ACT)
      pendValid_reg <= 1'b0;
  end

  // Pointer and countdown load on the activate op-code itself
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      rdPtr_reg <= 6'h00;
      remain_reg <= 7'h00;
    end
    else if (actHit)
    begin
      rdPtr_reg <= pendStart_reg;
      remain_reg <= pendValid_reg ? pendCount_reg : 7'h00;
    end
    else if (frameEnd)
      remain_reg <= 7'h00;
    else if (serveHit)
    begin
      rdPtr_reg <= rdPtr_reg + 6'h01;
      remain_reg <= remain_reg - 7'h01;
    end
  end

  // Data out only while activate serves bytes
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      txData <= 8'h00;
      txValid <= 1'b0;
    end
    else
    begin
      txValid <= serveHit;
      if (serveHit)
        txData <= curByte;
    end
  end

  // Errors: bad request, unknown op-code, wrong clear mask length, activate with nothing pending, or overrun
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
      cmdError <= 1'b0;
    else
      cmdError <= (pfDone && !reqLegal)
        || (actHit && !pendValid_reg)
        || (txReq && state_reg == DRP_ACT && remain_reg == 7'h00)
        || (frameEnd && state_reg == DRP_CLR && !clrDone)
        || (rxValid && state_reg == DRP_OPC && state_next == DRP_DROP);
  end

  // ==========================================================
  // Status store; a set in the clear cycle wins
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      for (int i = 0; i < STORE_BYTES; i++)
        store[i] <= STORE_RESET;
    end
    else
    begin
      for (int i = 0; i < STORE_BYTES; i++)
        if (clrDone && clrMask_reg[i])
          store[i] <= STORE_RESET;
      if (statusSetEn)
        store[statusSetIdx] <= statusSetData;
    end
  end

  // ==========================================================
  // Checks
  a_tx_only_active: assert property (
    @(posedge clk_sys) disable iff (!rstSync)
    txValid |-> $past(state_reg) == DRP_ACT)
    else $error("read data sent outside retrieval");
  a_tx_data_order: assert property (
    @(posedge clk_sys) disable iff (!rstSync)
    txValid |-> txData == $past(curByte)
      && rdPtr_reg == $past(rdPtr_reg) + 6'h01)
    else $error("read byte not taken in store order");
  a_immediate_serve: assert property (
    @(posedge clk_sys) disable iff (!rstSync)
    (actHit && pendValid_reg) |=> remain_reg == $past(pendCount_reg)
      && rdPtr_reg == $past(pendStart_reg))
    else $error("pending read not ready at activate");
  a_count_bound: assert property (
    @(posedge clk_sys) disable iff (!rstSync)
    txValid |-> $past(remain_reg) != 7'h00)
    else $error("more bytes sent than pending count");
  a_newest_kept: assert property (
    @(posedge clk_sys) disable iff (!rstSync)
    (pfDone && reqLegal) |=> pendValid_reg
      && pendCount_reg == $past(parCount[6:0]))
    else $error("newest request not made pending");
  a_bad_param_err: assert property (
    @(posedge clk_sys) disable iff (!rstSync)
    (pfDone && !reqLegal) |=> cmdError && !pendValid_reg)
    else $error("illegal request not flagged");
  a_clear_byte0: assert property (
    @(posedge clk_sys) disable iff (!rstSync)
    (clrDone && clrMask_reg[0] && !statusSetEn) |=> store[0] == STORE_RESET)
    else $error("masked status byte not cleared");
  a_keep_byte0: assert property (
    @(posedge clk_sys) disable iff (!rstSync)
    (clrDone && !clrMask_reg[0] && !statusSetEn) |=> $stable(store[0]))
    else $error("unmasked status byte changed");

endmodule
`default_nettype wire

// File: design/drp_pkg.sv
// Constants for the diagnostic read port command interpreter
`default_nettype none
package drp_pkg;
  // Command op-codes
  localparam logic [7:0] OP_PREFETCH = 8'h01;
  localparam logic [7:0] OP_ACTIVATE = 8'h02;
  localparam logic [7:0] OP_STATUS_RD = 8'hF0;
  localparam logic [7:0] OP_STATUS_CLR = 8'hF1;
  // Diagnostic status store geometry
  localparam int STORE_BYTES = 64;
  localparam logic [7:0] STORE_RESET = 8'h00;
  // Parameter byte counts per command
  localparam logic [3:0] STATUS_RD_PARAMS = 4'h4;
  localparam logic [3:0] CLR_MASK_BYTES = 4'h8;
  localparam logic [3:0] PARAM_CNT_MAX = 4'hF;
  // Field positions inside the collected status-read parameters
  localparam int START_LSB = 0;
  localparam int COUNT_LSB = 16;
  // Legal limits of the status-read parameters
  localparam logic [15:0] START_MAX = 16'h003F;
  localparam logic [15:0] COUNT_MIN = 16'h0001;
  localparam logic [16:0] SPAN_MAX = 17'h00040;
  // Interpreter states
  typedef enum logic [2:0] {
    DRP_IDLE, DRP_OPC, DRP_PFOP, DRP_PFPAR, DRP_CLR, DRP_ACT, DRP_DROP
  } drp_state_t;
endpackage
`default_nettype wire

// File: tb/drp_host_model.sv
// Host model: command master on the diagnostic byte stream
`default_nettype none
module drp_host_model
  import drp_pkg::*;
(
  input wire logic clk_sys,
  output logic frameStart,
  output logic frameEnd,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic txReq
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet lines at time zero
  initial {frameStart, frameEnd, rxValid, rxData, txReq} = '0;
  // ==========================================
  // Write frame: op-code, then its parameters
  task automatic sendFrame(input logic [7:0] b[$]);
    begin
      @(negedge clk_sys);
      frameStart = 1'b1;
      foreach (b[i])
      begin
        @(negedge clk_sys);
        frameStart = 1'b0;
        rxValid = 1'b1;
        rxData = b[i];
      end
      @(negedge clk_sys);
      rxValid = 1'b0;
      rxData = ~rxData; // No stale byte once released
      frameEnd = 1'b1;
      @(negedge clk_sys);
      frameEnd = 1'b0;
    end
  endtask
  // ==========================================
  // Retrieval frame: no polling, n byte requests
  task automatic readFrame(input int n);
    begin
      @(negedge clk_sys);
      frameStart = 1'b1;
      @(negedge clk_sys);
      frameStart = 1'b0;
      rxValid = 1'b1;
      rxData = OP_ACTIVATE;
      @(negedge clk_sys);
      rxValid = 1'b0;
      rxData = ~rxData;
      txReq = 1'b1;
      repeat (n) @(negedge clk_sys);
      txReq = 1'b0;
      repeat (2) @(negedge clk_sys);
      frameEnd = 1'b1;
      @(negedge clk_sys);
      frameEnd = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Testbench: self-checking scenarios for the diagnostic read port
`default_nettype none
module tb
  import drp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic frameStart, frameEnd, rxValid, txReq, statusSetEn;
  logic txValid, cmdError, pendingValid;
  logic [7:0] rxData, statusSetData, txData;
  logic [5:0] statusSetIdx;
  logic [7:0] store [64];
  logic [7:0] gotQ [$];
  int numErrors = 0;
  int comparisons = 0;
  int errSeen = 0;
  // ==========================================
  // Clock, parts and watchers
  always #50 clk_sys = ~clk_sys;
  drp_host_model u_drp_host_model (.clk_sys(clk_sys),
    .frameStart(frameStart), .frameEnd(frameEnd), .rxValid(rxValid),
    .rxData(rxData), .txReq(txReq));
  drp_diag_read_port u_drp_diag_read_port (.clk_sys(clk_sys),
    .rst_n(rst_n), .frameStart(frameStart), .frameEnd(frameEnd),
    .rxValid(rxValid), .rxData(rxData), .txReq(txReq),
    .statusSetEn(statusSetEn), .statusSetIdx(statusSetIdx),
    .statusSetData(statusSetData), .txData(txData), .txValid(txValid),
    .cmdError(cmdError), .pendingValid(pendingValid));
  // Collect read bytes and error pulses
  always @(posedge clk_sys)
  begin
    if (txValid === 1'b1) gotQ.push_back(txData);
    if (cmdError === 1'b1) errSeen++;
  end
  // ==========================================
  // Compare and closing tasks
  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      numErrors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic checkFlag(input logic got, input logic exp);
    checkVal({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic giveVerdict();
    $display("errors %0d comparisons %0d", numErrors, comparisons);
    if (numErrors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // Helpers: store writes, request, retrieval
  task automatic setByte(input int i, input logic [7:0] v);
    @(negedge clk_sys);
    statusSetEn = 1'b1;
    statusSetIdx = 6'(i);
    statusSetData = v;
    store[i] = v;
    @(negedge clk_sys);
    statusSetEn = 1'b0;
  endtask
  task automatic prefetch(input logic [15:0] s, input logic [15:0] c);
    gotQ.delete();
    u_drp_host_model.sendFrame({OP_PREFETCH, OP_STATUS_RD, s[7:0],
      s[15:8], c[7:0], c[15:8]});
    checkVal(16'(gotQ.size()), 16'h0000);
  endtask
  task automatic readBack(input int s, input int c);
    int e0;
    begin
      e0 = errSeen;
      gotQ.delete();
      u_drp_host_model.readFrame(c);
      checkVal(16'(gotQ.size()), 16'(c));
      foreach (gotQ[i])
        checkVal({8'h00, gotQ[i]}, {8'h00, store[s + i]});
      checkVal(16'(errSeen - e0), 16'h0000);
      checkFlag(pendingValid, 1'b0);
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic basicRead();
    int e0;
    begin
      for (int i = 0; i < STORE_BYTES; i++)
        setByte(i, 8'(i * 29) ^ 8'h5A);
      prefetch(16'h0000, 16'h0040);
      readBack(0, 64);
      prefetch(16'h003C, 16'h0004);
      @(negedge clk_sys);
      checkFlag(pendingValid, 1'b1);
      e0 = errSeen;
      gotQ.delete();
      u_drp_host_model.readFrame(5);
      checkVal(16'(gotQ.size()), 16'h0004);
      checkVal(16'(errSeen - e0), 16'h0001);
    end
  endtask
  task automatic rangeCheck();
    logic [31:0] bad [5] = '{32'h003F0002, 32'h00000000, 32'h00400001,
      32'h00000041, 32'h01000001};
    int e0;
    begin
      foreach (bad[i])
      begin
        e0 = errSeen;
        prefetch(bad[i][31:16], bad[i][15:0]);
        @(negedge clk_sys);
        checkVal(16'(errSeen - e0), 16'h0001);
        checkFlag(pendingValid, 1'b0);
      end
      e0 = errSeen;
      gotQ.delete();
      u_drp_host_model.readFrame(1);
      checkVal(16'(gotQ.size()), 16'h0000);
      checkFlag(errSeen > e0, 1'b1);
    end
  endtask
  task automatic opcodeCheck();
    int e0;
    begin
      e0 = errSeen;
      u_drp_host_model.sendFrame({OP_PREFETCH, 8'hC1});
      @(negedge clk_sys);
      checkFlag(errSeen > e0, 1'b1);
      checkFlag(pendingValid, 1'b0);
      e0 = errSeen;
      u_drp_host_model.sendFrame({8'h33});
      @(negedge clk_sys);
      checkFlag(errSeen > e0, 1'b1);
      // Request cut after its own op-code drops the older pending read
      prefetch(16'h0000, 16'h0001);
      e0 = errSeen;
      u_drp_host_model.sendFrame({OP_PREFETCH});
      @(negedge clk_sys);
      checkFlag(errSeen > e0, 1'b1);
      checkFlag(pendingValid, 1'b0);
      prefetch(16'h0000, 16'h0001);
      prefetch(16'h000A, 16'h0003);
      readBack(10, 3);
    end
  endtask
  task automatic clearCheck();
    logic [7:0] m [$] = '{8'h81, 8'h00, 8'hFF, 8'h01, 8'h80, 8'h5A,
      8'h00, 8'hC3};
    int e0;
    begin
      e0 = errSeen;
      // Seven mask bytes only: store must stay as it is
      u_drp_host_model.sendFrame({OP_STATUS_CLR, m[0:6]});
      @(negedge clk_sys);
      checkFlag(errSeen > e0, 1'b1);
      prefetch(16'h0000, 16'h0040);
      readBack(0, 64);
      u_drp_host_model.sendFrame({OP_STATUS_CLR, m});
      for (int i = 0; i < STORE_BYTES; i++)
        if (m[i / 8][i % 8]) store[i] = 8'h00;
      prefetch(16'h0000, 16'h0040);
      readBack(0, 64);
    end
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    {statusSetEn, statusSetIdx, statusSetData} = '0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    basicRead();
    rangeCheck();
    opcodeCheck();
    clearCheck();
    giveVerdict();
  end
  // About 530 cycles expected; a hang stops at 6000
  initial
  begin
    repeat (6000) @(posedge clk_sys);
    numErrors++;
    giveVerdict();
  end
endmodule
`default_nettype wire
